// [sscfg_bank.v]
`timescale 1ns/10ps
`include "sscfg_defs.vh"

// Function
// RULE_01 - Two configuration lines, each 16 data bits plus 6 check bits.
// RULE_02 - Line one bit 15 picks uncalibrated hysteresis: 0 is 25%, 1 is 31.25%.
// RULE_03 - Line one bit 14 enables stop mode; default on.
// RULE_04 - Line one bit 13 set freezes pulse and phase above 1.5kHz; default set.
// RULE_05 - Line one bit 12 picks direction-change criterion: quarter or eighth.
// RULE_06 - Line one bit 11 switches the system watchdog; default off.
// RULE_07 - Line one bits 10:9 set path delay 14, 17, 20 or 23 microseconds.
// RULE_08 - Three-bit code sets forward, reverse and standstill pulse widths.
// RULE_09 - Bit 5 picks 40 or 80 ms standstill delay, only when enabled.
// RULE_10 - Bit 4 set holds calibration for 1.4 s after power on.
// RULE_11 - Bit 3 sets first-edge behaviour, only with pulse-width code 110.
// RULE_12 - Bit 2 set suppresses calibration during hybrid electric drive.
// RULE_13 - Bit 1 set enables the optional standstill pulse; the code keeps it off with pulse-width code 110.
// RULE_14 - Bit 0 picks startup back-bias calibration or centred back bias.
// RULE_15 - Line two bits 15:12 hold the switching-threshold factor, default 0111.
// RULE_16 - Threshold is minimum plus factor times maximum minus minimum.
// RULE_17 - Each line read corrects a single-bit error before use.

module sscfg_bank #(
  parameter SS_TMO0_CYC = `SSCFG_SS_TMO0_MS * 1000000 / `SSCFG_CLK_NS,
  parameter SS_TMO1_CYC = `SSCFG_SS_TMO1_MS * 1000000 / `SSCFG_CLK_NS,
  parameter PWR_TMO_CYC = `SSCFG_PWR_TMO_MS * 1000000 / `SSCFG_CLK_NS
) (
  input  wire        i_clk_sys,
  input  wire        i_reset,
  input  wire        i_wr_en,
  input  wire        i_wr_addr,
  input  wire [15:0] i_wr_data,
  input  wire        i_wr_raw,
  input  wire [5:0]  i_wr_check,
  input  wire        i_rd_en,
  input  wire        i_rd_addr,
  output reg  [15:0] o_rd_data,
  output reg         o_rd_valid,
  output reg         o_rd_corrected,
  output reg         o_rd_uncorrectable,
  output reg         o_ecc_corrected,
  output reg         o_ecc_failed,
  input  wire        i_pulse_sent,
  input  wire [15:0] i_bmin,
  input  wire [15:0] i_bmax,
  output reg         o_uncal_hysteresis_sel,
  output reg         o_stop_enable,
  output reg         o_high_speed_freeze,
  output reg         o_dir_change_eighth,
  output reg         o_system_watchdog_en,
  output reg  [15:0] o_delay_cycles,
  output reg  [15:0] o_fwd_width_cycles,
  output reg  [15:0] o_rev_width_cycles,
  output reg  [15:0] o_ss_width_cycles,
  output reg         o_oem_protocol,
  output reg         o_first_edge_behaviour,
  output reg         o_standstill_en,
  output reg         o_standstill_pulse,
  output reg         o_cal_hold,
  output reg         o_hybrid_watchdog_en,
  output reg         o_back_bias_centre,
  output reg  [5:0]  o_k_factor,
  output reg  [15:0] o_switch_threshold
);

  function [15:0] us2cyc;
    input integer us;
    integer       t;
    begin
      t      = us * 1000 / `SSCFG_CLK_NS;
      us2cyc = t[15:0];
    end
  endfunction

  localparam [27:0] SS_TMO0 = SS_TMO0_CYC[27:0];
  localparam [27:0] SS_TMO1 = SS_TMO1_CYC[27:0];
  localparam [27:0] PWR_TMO = PWR_TMO_CYC[27:0];

  // Write path: encode unless a raw check word is forced
  wire [5:0]  enc_check;
  wire [21:0] wr_word;
  wire        rd_addr;
  wire [21:0] mem_word;
  wire        mem_blank;
  wire [15:0] dec_data;
  wire        dec_single;
  wire        dec_double;

  reg         scan_line_q;
  reg         rd_pend_q;
  reg         rd_host_q;
  reg         rd_line_q;
  reg  [15:0] line_one_q;
  reg  [15:0] line_two_q;
  reg  [15:0] good_data;
  reg  [15:0] fwd_us;
  reg  [15:0] rev_us;
  reg  [15:0] ss_us;
  reg  [15:0] dly_cyc;
  reg  [27:0] pwr_cnt_q;
  reg  [27:0] ss_cnt_q;
  reg         ss_run_q;
  reg  [15:0] span;
  reg  [21:0] prod;
  reg  [16:0] thr_sum;
  reg  [2:0]  pw_code;
  reg         ss_active;

  assign wr_word = {i_wr_raw ? i_wr_check : enc_check, i_wr_data}; // RULE_01
  // Host read wins the single read port; scan takes the idle cycles
  assign rd_addr = i_rd_en ? i_rd_addr : scan_line_q;

  sscfg_ecc u_ecc (
    .i_enc_data   (i_wr_data),
    .o_enc_check  (enc_check),
    .i_dec_data   (mem_word[15:0]),
    .i_dec_check  (mem_word[21:16]),
    .o_dec_data   (dec_data),
    .o_dec_single (dec_single),
    .o_dec_double (dec_double)
  );

  sscfg_store u_store (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_wr_en    (i_wr_en),
    .i_wr_addr  (i_wr_addr),
    .i_wr_word  (wr_word),
    .i_rd_addr  (rd_addr),
    .o_rd_word  (mem_word),
    .o_rd_blank (mem_blank)
  );

  // Blank lines read as their defaults with no error
  always @* begin
    if (mem_blank) begin
      good_data = (rd_line_q == `SSCFG_ADDR_LINE_TWO) ? `SSCFG_L2_DEFAULT : `SSCFG_L1_DEFAULT;
    end else begin
      good_data = dec_data; // RULE_17
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      scan_line_q <= `SSCFG_ADDR_LINE_ONE;
      rd_pend_q   <= 1'b0;
      rd_host_q   <= 1'b0;
      rd_line_q   <= `SSCFG_ADDR_LINE_ONE;
    end else begin
      rd_pend_q <= 1'b1;
      rd_host_q <= i_rd_en;
      rd_line_q <= rd_addr;
      if (!i_rd_en) begin
        scan_line_q <= ~scan_line_q;
      end
    end
  end

  // Read answers and applied copies of the two lines
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_data          <= 16'h0000;
      o_rd_valid         <= 1'b0;
      o_rd_corrected     <= 1'b0;
      o_rd_uncorrectable <= 1'b0;
      o_ecc_corrected    <= 1'b0;
      o_ecc_failed       <= 1'b0;
      line_one_q         <= `SSCFG_L1_DEFAULT;
      line_two_q         <= `SSCFG_L2_DEFAULT;
    end else begin
      o_rd_valid      <= rd_pend_q && rd_host_q;
      o_ecc_corrected <= 1'b0;
      if (rd_pend_q && rd_host_q) begin
        o_rd_data          <= good_data; // RULE_17
        o_rd_corrected     <= dec_single && !mem_blank;
        o_rd_uncorrectable <= dec_double && !mem_blank;
      end
      if (rd_pend_q && !rd_host_q) begin
        o_ecc_corrected <= dec_single && !mem_blank;
        o_ecc_failed    <= dec_double && !mem_blank;
        // A double error keeps the last good settings in force
        if (!(dec_double && !mem_blank)) begin
          if (rd_line_q == `SSCFG_ADDR_LINE_TWO) begin
            line_two_q <= good_data; // RULE_17
          end else begin
            line_one_q <= good_data; // RULE_17
          end
        end
      end
    end
  end

  // Pulse-width table; code 010 has no entry and falls back to 000
  always @* begin
    pw_code = line_one_q[`SSCFG_L1_PW_MSB:`SSCFG_L1_PW_LSB];
    case (pw_code)
      3'h1: {fwd_us, rev_us, ss_us} = {`SSCFG_PW1_US}; // RULE_08
      3'h3: {fwd_us, rev_us, ss_us} = {`SSCFG_PW3_US}; // RULE_08
      3'h4: {fwd_us, rev_us, ss_us} = {`SSCFG_PW4_US}; // RULE_08
      3'h5: {fwd_us, rev_us, ss_us} = {`SSCFG_PW5_US}; // RULE_08
      3'h6: {fwd_us, rev_us, ss_us} = {`SSCFG_PW6_US}; // RULE_08
      3'h7: {fwd_us, rev_us, ss_us} = {`SSCFG_PW7_US}; // RULE_08
      default: {fwd_us, rev_us, ss_us} = {`SSCFG_PW0_US}; // RULE_08
    endcase
  end

  always @* begin
    case (line_one_q[`SSCFG_L1_DELAY_MSB:`SSCFG_L1_DELAY_LSB])
      2'h1: dly_cyc = us2cyc(`SSCFG_DLY1_US); // RULE_07
      2'h2: dly_cyc = us2cyc(`SSCFG_DLY2_US); // RULE_07
      2'h3: dly_cyc = us2cyc(`SSCFG_DLY3_US); // RULE_07
      default: dly_cyc = us2cyc(`SSCFG_DLY0_US); // RULE_07
    endcase
  end

  // The OEM code has no standstill pulse, whatever bit 1 says
  always @* begin
    ss_active = line_one_q[`SSCFG_L1_SS_EN] && (pw_code != `SSCFG_PW_OEM); // RULE_13
  end

  // Threshold arithmetic assumes the caller keeps maximum at or above minimum
  always @* begin
    span    = i_bmax - i_bmin;
    prod    = span * o_k_factor; // RULE_16
    thr_sum = {1'b0, i_bmin} + {1'b0, prod[21:`SSCFG_K_SHIFT]}; // RULE_16
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_uncal_hysteresis_sel <= 1'b0;
      o_stop_enable          <= 1'b1;
      o_high_speed_freeze    <= 1'b1;
      o_dir_change_eighth    <= 1'b0;
      o_system_watchdog_en   <= 1'b0;
      o_delay_cycles         <= 16'h0000;
      o_fwd_width_cycles     <= 16'h0000;
      o_rev_width_cycles     <= 16'h0000;
      o_ss_width_cycles      <= 16'h0000;
      o_oem_protocol         <= 1'b0;
      o_first_edge_behaviour <= 1'b0;
      o_standstill_en        <= 1'b0;
      o_hybrid_watchdog_en   <= 1'b0;
      o_back_bias_centre     <= 1'b0;
      o_k_factor             <= 6'h00;
      o_switch_threshold     <= 16'h0000;
    end else begin
      o_uncal_hysteresis_sel <= line_one_q[`SSCFG_L1_UNCAL_HYST]; // RULE_02
      o_stop_enable          <= line_one_q[`SSCFG_L1_STOP_EN]; // RULE_03
      o_high_speed_freeze    <= line_one_q[`SSCFG_L1_HIGH_SPEED]; // RULE_04
      o_dir_change_eighth    <= line_one_q[`SSCFG_L1_DIR_CHANGE]; // RULE_05
      o_system_watchdog_en   <= line_one_q[`SSCFG_L1_SYS_WDOG]; // RULE_06
      o_delay_cycles         <= dly_cyc; // RULE_07
      o_fwd_width_cycles     <= us2cyc(fwd_us); // RULE_08
      o_rev_width_cycles     <= us2cyc(rev_us); // RULE_08
      o_ss_width_cycles      <= ss_active ? us2cyc(ss_us) : 16'h0000; // RULE_08
      o_oem_protocol         <= (pw_code == `SSCFG_PW_OEM);
      o_first_edge_behaviour <= (pw_code == `SSCFG_PW_OEM) && line_one_q[`SSCFG_L1_FIRST_EDGE]; // RULE_11
      o_standstill_en        <= ss_active; // RULE_13
      o_hybrid_watchdog_en   <= line_one_q[`SSCFG_L1_HYBRID]; // RULE_12
      o_back_bias_centre     <= line_one_q[`SSCFG_L1_BACK_BIAS]; // RULE_14
      o_k_factor             <= `SSCFG_K_BASE + {2'h0, line_two_q[`SSCFG_L2_KF_MSB:`SSCFG_L2_KF_LSB]}; // RULE_15
      o_switch_threshold     <= thr_sum[15:0]; // RULE_16
    end
  end

  // Power-on calibration hold, counted from reset release
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      pwr_cnt_q  <= 28'h000_0000;
      o_cal_hold <= 1'b0;
    end else begin
      if (pwr_cnt_q < PWR_TMO) begin
        pwr_cnt_q <= pwr_cnt_q + 28'h000_0001;
      end
      o_cal_hold <= line_one_q[`SSCFG_L1_PWR_TIMEOUT] && (pwr_cnt_q < PWR_TMO); // RULE_10
    end
  end

  // Standstill pulse request after the chosen quiet time; each sent pulse restarts it
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      ss_cnt_q           <= 28'h000_0000;
      ss_run_q           <= 1'b0;
      o_standstill_pulse <= 1'b0;
    end else begin
      o_standstill_pulse <= 1'b0;
      if (i_pulse_sent) begin
        ss_cnt_q <= line_one_q[`SSCFG_L1_SS_TIMEOUT] ? SS_TMO1 : SS_TMO0; // RULE_09
        ss_run_q <= 1'b1;
      end else if (ss_run_q) begin
        if (ss_cnt_q <= 28'h000_0001) begin
          ss_run_q           <= 1'b0;
          o_standstill_pulse <= ss_active; // RULE_09
        end else begin
          ss_cnt_q <= ss_cnt_q - 28'h000_0001;
        end
      end
    end
  end

endmodule // sscfg_bank

// [sscfg_defs.vh]
`ifndef SSCFG_DEFS_VH
`define SSCFG_DEFS_VH

// Line addresses
`define SSCFG_ADDR_LINE_ONE   1'h0
`define SSCFG_ADDR_LINE_TWO   1'h1

// Word layout
`define SSCFG_DATA_W          16
`define SSCFG_CHECK_W         6

// First line field positions
`define SSCFG_L1_UNCAL_HYST   15
`define SSCFG_L1_STOP_EN      14
`define SSCFG_L1_HIGH_SPEED   13
`define SSCFG_L1_DIR_CHANGE   12
`define SSCFG_L1_SYS_WDOG     11
`define SSCFG_L1_DELAY_MSB    10
`define SSCFG_L1_DELAY_LSB    9
`define SSCFG_L1_PW_MSB       8
`define SSCFG_L1_PW_LSB       6
`define SSCFG_L1_SS_TIMEOUT   5
`define SSCFG_L1_PWR_TIMEOUT  4
`define SSCFG_L1_FIRST_EDGE   3
`define SSCFG_L1_HYBRID       2
`define SSCFG_L1_SS_EN        1
`define SSCFG_L1_BACK_BIAS    0

// Second line field positions
`define SSCFG_L2_KF_MSB       15
`define SSCFG_L2_KF_LSB       12

// Reset values of a blank line
`define SSCFG_L1_DEFAULT      16'h6000
`define SSCFG_L2_DEFAULT      16'h7424

// Pulse-width code without standstill pulse
`define SSCFG_PW_OEM          3'h6

// Timing
`define SSCFG_CLK_NS          10
`define SSCFG_DLY0_US         14
`define SSCFG_DLY1_US         17
`define SSCFG_DLY2_US         20
`define SSCFG_DLY3_US         23
`define SSCFG_SS_TMO0_MS      40
`define SSCFG_SS_TMO1_MS      80
`define SSCFG_PWR_TMO_MS      1400

// Pulse widths in microseconds: forward / reverse / standstill
`define SSCFG_PW0_US          16'h002D, 16'h005A, 16'h00B4
`define SSCFG_PW1_US          16'h002D, 16'h00B4, 16'h0168
`define SSCFG_PW3_US          16'h004B, 16'h0258, 16'h0168
`define SSCFG_PW4_US          16'h0016, 16'h002D, 16'h005A
`define SSCFG_PW5_US          16'h003C, 16'h0078, 16'h0168
`define SSCFG_PW6_US          16'h001E, 16'h003C, 16'h0000
`define SSCFG_PW7_US          16'h005A, 16'h0087, 16'h0168

// Threshold factor: k = (base + code) / 64
`define SSCFG_K_BASE          6'h19
`define SSCFG_K_SHIFT         6

`endif

// [sscfg_store.v]
`timescale 1ns/10ps
`include "sscfg_defs.vh"

module sscfg_store (
  input  wire                                        i_clk_sys,
  input  wire                                        i_reset,
  input  wire                                        i_wr_en,
  input  wire                                        i_wr_addr,
  input  wire [`SSCFG_DATA_W+`SSCFG_CHECK_W-1:0]     i_wr_word,
  input  wire                                        i_rd_addr,
  output reg  [`SSCFG_DATA_W+`SSCFG_CHECK_W-1:0]     o_rd_word,
  output reg                                         o_rd_blank
);

  reg [`SSCFG_DATA_W+`SSCFG_CHECK_W-1:0] mem [0:1];
  // Non-volatile: contents survive reset; only a never-written line is blank
  reg [1:0] blank;

  initial begin
    blank = 2'h3;
  end

  always @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr]   <= i_wr_word;
      blank[i_wr_addr] <= 1'b0;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_word  <= {(`SSCFG_DATA_W+`SSCFG_CHECK_W){1'b0}};
      o_rd_blank <= 1'b1;
    end else begin
      o_rd_word  <= mem[i_rd_addr];
      o_rd_blank <= blank[i_rd_addr];
    end
  end

endmodule // sscfg_store

// [sscfg_ecc.v]
`timescale 1ns/10ps
`include "sscfg_defs.vh"

module sscfg_ecc (
  input  wire [`SSCFG_DATA_W-1:0]  i_enc_data,
  output reg  [`SSCFG_CHECK_W-1:0] o_enc_check,
  input  wire [`SSCFG_DATA_W-1:0]  i_dec_data,
  input  wire [`SSCFG_CHECK_W-1:0] i_dec_check,
  output reg  [`SSCFG_DATA_W-1:0]  o_dec_data,
  output reg                       o_dec_single,
  output reg                       o_dec_double
);

  // Hamming over positions 1..21 plus an overall parity bit
  reg [21:0] ecw;
  reg [21:0] dcw;
  reg [4:0]  syn;
  reg        par;
  reg        epar;
  reg        ovr;
  integer    p;
  integer    j;
  integer    k;
  // Encoder has its own loop variables so no variable has two drivers
  integer    ep;
  integer    ej;
  integer    ek;

  always @* begin
    ecw  = 22'h00_0000;
    ej   = 0;
    epar = 1'b0;
    o_enc_check = 6'h00;
    for (ep = 1; ep < 22; ep = ep + 1) begin
      if ((ep & (ep - 1)) != 0) begin
        ecw[ep] = i_enc_data[ej];
        ej = ej + 1;
      end
    end
    for (ek = 0; ek < 5; ek = ek + 1) begin
      epar = 1'b0;
      for (ep = 1; ep < 22; ep = ep + 1) begin
        if (ep[ek]) epar = epar ^ ecw[ep];
      end
      o_enc_check[ek] = epar;
    end
    o_enc_check[5] = ^{i_enc_data, o_enc_check[4:0]};
  end

  always @* begin
    dcw = 22'h00_0000;
    j   = 0;
    syn = 5'h00;
    par = 1'b0;
    o_dec_data = 16'h0000;
    for (p = 1; p < 22; p = p + 1) begin
      if ((p & (p - 1)) != 0) begin
        dcw[p] = i_dec_data[j];
        j = j + 1;
      end
    end
    for (k = 0; k < 5; k = k + 1) begin
      dcw[1 << k] = i_dec_check[k];
    end
    for (k = 0; k < 5; k = k + 1) begin
      par = 1'b0;
      for (p = 1; p < 22; p = p + 1) begin
        if (p[k]) par = par ^ dcw[p];
      end
      syn[k] = par;
    end
    ovr = ^{i_dec_data, i_dec_check};
    // Odd overall parity means one flipped bit; a syndrome past 21 cannot be one
    o_dec_single = ovr && (syn < 5'h16);
    o_dec_double = (syn != 5'h00) && !o_dec_single;
    if (o_dec_single && (syn != 5'h00)) dcw[syn] = ~dcw[syn];
    j = 0;
    for (p = 1; p < 22; p = p + 1) begin
      if ((p & (p - 1)) != 0) begin
        o_dec_data[j] = dcw[p];
        j = j + 1;
      end
    end
  end

endmodule // sscfg_ecc

// [sscfg_bank_chk.sv]
`timescale 1ns/10ps
module sscfg_bank_chk #(
  parameter PWR_TMO_CYC = 50
) (
  input wire        i_clk_sys,
  input wire        i_reset,
  input wire        i_rd_en,
  input wire        i_pulse_sent,
  input wire [15:0] i_bmin,
  input wire [15:0] i_bmax,
  input wire        o_rd_valid,
  input wire        o_oem_protocol,
  input wire        o_first_edge_behaviour,
  input wire        o_standstill_en,
  input wire        o_standstill_pulse,
  input wire        o_cal_hold,
  input wire [15:0] o_delay_cycles,
  input wire [15:0] o_ss_width_cycles,
  input wire [5:0]  o_k_factor,
  input wire [15:0] o_switch_threshold
);
  logic [31:0] run_q;
  logic [31:0] prod;
  logic [15:0] thr_exp;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // Edges since reset release, saturating so a long run never wraps
  always @(posedge i_clk_sys) begin
    if (i_reset)
      run_q <= 32'h0000_0000;
    else if (run_q != 32'hFFFF_FFFF)
      run_q <= run_q + 32'h0000_0001;
  end

  always @* begin
    prod    = {16'h0000, i_bmax - i_bmin} * {26'h000_0000, o_k_factor};
    thr_exp = i_bmin + prod[21:6];
  end

  AST_RD_LATENCY: assert property (i_rd_en |-> ##2 o_rd_valid)
    else $error("read answer missing two cycles after request");
  AST_RD_CAUSE: assert property (o_rd_valid |-> $past(i_rd_en, 2))
    else $error("read answer without a request");
  AST_FIRST_EDGE: assert property (o_first_edge_behaviour |-> o_oem_protocol)
    else $error("first edge behaviour outside pulse code 110");
  AST_SS_OEM: assert property (o_standstill_en |-> !o_oem_protocol && o_ss_width_cycles != 16'h0000)
    else $error("standstill enabled with no width or with code 110");
  AST_SS_WIDTH: assert property (!o_standstill_en |-> o_ss_width_cycles == 16'h0000)
    else $error("standstill width nonzero while disabled");
  AST_DELAY: assert property (run_q > 32'h0000_0004 |->
    o_delay_cycles inside {16'h0578, 16'h06A4, 16'h07D0, 16'h08FC})
    else $error("path delay not one of four settings");
  AST_KF_RANGE: assert property (run_q > 32'h0000_0004 |-> o_k_factor inside {[6'h19:6'h28]})
    else $error("threshold factor out of range");
  AST_SS_QUIET: assert property (i_pulse_sent |-> ##2 !o_standstill_pulse [*8])
    else $error("standstill pulse right after a sent pulse");
  AST_SS_SRC: assert property (o_standstill_pulse |-> $past(o_standstill_en))
    else $error("standstill pulse while disabled");
  AST_CAL_HOLD: assert property (o_cal_hold |-> run_q <= PWR_TMO_CYC + 4)
    else $error("calibration hold past power-on timeout");
  AST_THRESH: assert property (run_q > 32'h0000_0004 && $stable(o_k_factor) && i_bmax >= i_bmin
    |=> o_switch_threshold == $past(thr_exp))
    else $error("switching threshold mismatch");
endmodule // sscfg_bank_chk

bind sscfg_bank sscfg_bank_chk #(.PWR_TMO_CYC(PWR_TMO_CYC)) u_chk (.*);

// [sscfg_bank_bench.sv]
`timescale 1ns/10ps
`include "sscfg_defs.vh"
module sscfg_bank_bench;
  localparam int SS0 = 20;
  localparam int SS1 = 40;
  localparam int PWR = 50;

  logic        i_clk_sys, i_reset, i_wr_en, i_wr_addr, i_wr_raw, i_rd_en, i_rd_addr, i_pulse_sent;
  logic [15:0] i_wr_data, i_bmin, i_bmax;
  logic [5:0]  i_wr_check;
  wire  [15:0] o_rd_data, o_delay_cycles, o_fwd_width_cycles, o_rev_width_cycles, o_ss_width_cycles;
  wire  [15:0] o_switch_threshold;
  wire  [5:0]  o_k_factor;
  wire         o_rd_valid, o_rd_corrected, o_rd_uncorrectable, o_ecc_corrected, o_ecc_failed;
  wire         o_uncal_hysteresis_sel, o_stop_enable, o_high_speed_freeze, o_dir_change_eighth;
  wire         o_system_watchdog_en, o_oem_protocol, o_first_edge_behaviour, o_standstill_en;
  wire         o_standstill_pulse, o_cal_hold, o_hybrid_watchdog_en, o_back_bias_centre;
  int          fails, compares, c, fw[8], rv[8], sw[8];
  logic [18:0] q[$];
  logic [15:0] mem[2], v, w;
  logic [1:0]  fl[2];

  sscfg_bank #(.SS_TMO0_CYC(SS0), .SS_TMO1_CYC(SS1), .PWR_TMO_CYC(PWR)) dut (.*);

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rd(input string n, input logic [15:0] e, input logic [15:0] g);
    chk({"read ", n}, e, g);
  endtask

  // Own Hamming encoder so corrupted words can be forced in
  function automatic logic [5:0] enc(input logic [15:0] d);
    logic [21:1] cw;
    logic [5:0]  k;
    int          j;
    cw = 21'h00_0000;
    k = 6'h00;
    j = 0;
    for (int p = 1; p <= 21; p++)
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    for (int i = 0; i < 5; i++)
      for (int p = 1; p <= 21; p++)
        if (p[i]) k[i] = k[i] ^ cw[p];
    k[5] = ^{cw, k[4:0]};
    return k;
  endfunction

  task automatic wr(input logic a, input logic [15:0] e, input logic [15:0] x, input logic [5:0] cx,
                    input logic [1:0] f);
    i_wr_en    = 1'b1;
    i_wr_addr  = a;
    i_wr_data  = e ^ x;
    i_wr_check = enc(e) ^ cx;
    i_wr_raw   = |{x, cx};
    mem[a]     = e;
    fl[a]      = f;
  endtask

  task automatic rd(input logic a);
    i_rd_en   = 1'b1;
    i_rd_addr = a;
    q.push_back({~fl[a][1], fl[a], mem[a]});
  endtask

  task automatic nx(input int n = 1);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // Extra edge after release so no strobe is raised twice in one step
  task automatic fin;
    nx();
    i_wr_en      = 1'b0;
    i_rd_en      = 1'b0;
    i_pulse_sent = 1'b0;
    nx();
  endtask

  task automatic check_l1(input logic [15:0] u);
    logic [2:0] pc;
    logic       se;
    pc = u[8:6];
    se = u[1] && pc != 3'h6;
    chk("hyst", 16'(u[15]), 16'(o_uncal_hysteresis_sel));
    chk("stop", 16'(u[14]), 16'(o_stop_enable));
    chk("freeze", 16'(u[13]), 16'(o_high_speed_freeze));
    chk("dir", 16'(u[12]), 16'(o_dir_change_eighth));
    chk("wdog", 16'(u[11]), 16'(o_system_watchdog_en));
    chk("delay", 16'(1400 + 300 * u[10:9]), o_delay_cycles);
    chk("fwd", 16'(fw[pc] * 100), o_fwd_width_cycles);
    chk("rev", 16'(rv[pc] * 100), o_rev_width_cycles);
    chk("ssw", se ? 16'(sw[pc] * 100) : 16'h0000, o_ss_width_cycles);
    chk("oem", 16'(pc == 3'h6), 16'(o_oem_protocol));
    chk("first", 16'(u[3] && pc == 3'h6), 16'(o_first_edge_behaviour));
    chk("hybrid", 16'(u[2]), 16'(o_hybrid_watchdog_en));
    chk("ssen", 16'(se), 16'(o_standstill_en));
    chk("bias", 16'(u[0]), 16'(o_back_bias_centre));
    chk("calhold", 16'h0000, 16'(o_cal_hold));
  endtask

  task automatic ss_run(input int n);
    int k;
    i_pulse_sent = 1'b1;
    nx();
    i_pulse_sent = 1'b0;
    k = 0;
    while (k < 100 && o_standstill_pulse !== 1'b1) begin
      nx();
      k++;
    end
    if (n == 0)
      chk("ss_absent", 16'h0000, 16'(o_standstill_pulse));
    else
      chk("ss_delay", 16'h0001, 16'(k >= n && k <= n + 2));
  endtask

  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(negedge i_clk_sys) begin
    logic [18:0] e;
    if (o_rd_valid === 1'b1) begin
      chk_rd("order", 16'h0001, 16'(q.size() != 0));
      if (q.size() != 0) begin
        e = q.pop_front();
        if (e[18]) chk_rd("data", e[15:0], o_rd_data);
        chk_rd("corr", 16'(e[16]), 16'(o_rd_corrected));
        chk_rd("unc", 16'(e[17]), 16'(o_rd_uncorrectable));
      end
    end
  end

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    $display("unexpected run length expected done seen timeout");
    fails++;
    stop_test();
  end

  initial begin
    fw = '{45, 45, 45, 75, 22, 60, 30, 90};
    rv = '{90, 180, 90, 600, 45, 120, 60, 135};
    sw = '{180, 360, 180, 360, 90, 360, 0, 360};
    mem = '{`SSCFG_L1_DEFAULT, `SSCFG_L2_DEFAULT};
    fl = '{2'h0, 2'h0};
    {i_wr_en, i_wr_addr, i_wr_raw, i_rd_en, i_rd_addr, i_pulse_sent} = 6'h00;
    {i_wr_data, i_bmin, i_bmax} = 48'h0000_0000_0000;
    i_wr_check = 6'h00;
    i_reset = 1'b1;
    void'($urandom(54));
    nx(12);
    i_reset = 1'b0;
    nx(6);
    check_l1(mem[0]);
    chk("kdef", 16'h0020, 16'(o_k_factor));
    rd(0);
    nx();
    rd(1);
    fin();
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      v[8:6] = 3'(i);
      v[10:9] = 2'(i);
      // Power-on hold may still run here; it is timed in its own scenario
      v[4] = 1'b0;
      wr(0, v, 16'h0000, 6'h00, 2'h0);
      fin();
      rd(0);
      fin();
      nx(4);
      check_l1(v);
    end
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom);
      v[15:12] = 4'(i);
      i_bmin = 16'($urandom) & 16'h7FFF;
      i_bmax = i_bmin + (16'($urandom) & 16'h7FFF);
      wr(1, v, 16'h0000, 6'h00, 2'h0);
      fin();
      nx(4);
      chk("kfac", 16'(25 + i), 16'(o_k_factor));
      chk("thr", 16'(i_bmin + (((i_bmax - i_bmin) * (25 + i)) >> 6)), o_switch_threshold);
    end
    rd(1);
    fin();
    for (int k = 0; k < 4; k++) begin
      v = k == 0 ? 16'h6002 : k == 1 ? 16'h6022 : k == 2 ? 16'h6182 : 16'h6000;
      wr(0, v, 16'h0000, 6'h00, 2'h0);
      fin();
      nx(4);
      ss_run(k == 0 ? SS0 : k == 1 ? SS1 : 0);
    end
    wr(0, 16'h6010, 16'h0000, 6'h00, 2'h0);
    fin();
    i_reset = 1'b1;
    nx(12);
    i_reset = 1'b0;
    nx(10);
    chk("calhold_on", 16'h0001, 16'(o_cal_hold));
    nx(PWR);
    chk("calhold_off", 16'h0000, 16'(o_cal_hold));
    rd(0);
    fin();
    v = 16'($urandom);
    wr(1, v, 16'h0100, 6'h00, 2'h1);
    fin();
    rd(1);
    fin();
    c = 0;
    while (c < 20 && o_ecc_corrected !== 1'b1) begin
      nx();
      c++;
    end
    chk("scanfix", 16'h0001, 16'(o_ecc_corrected));
    w = 16'($urandom);
    rd(1);
    wr(1, w, 16'h0000, 6'h04, 2'h1);
    fin();
    rd(1);
    fin();
    wr(1, v, 16'h0003, 6'h00, 2'h2);
    fin();
    rd(1);
    fin();
    c = 0;
    // Level follows the line last scanned, so it drops while line one is scanned
    while (c < 20 && o_ecc_failed !== 1'b1) begin
      nx();
      c++;
    end
    chk("eccfail", 16'h0001, 16'(o_ecc_failed));
    chk("kkeep", 16'(25 + w[15:12]), 16'(o_k_factor));
    c = 0;
    while (c < 20 && q.size() != 0) begin
      nx();
      c++;
    end
    chk("pending", 16'h0000, 16'(q.size()));
    stop_test();
  end
endmodule // sscfg_bank_bench
